//--- sorb_defs.svh
// Purpose: constants of the supported opcode report builder
// Assumes: included by the package and the builder; guarded
// Notes:   byte offsets are within the unit being sent
`ifndef SORB_DEFS_SVH
`define SORB_DEFS_SVH
`define SORB_NUM_CMDS   4'h5
`define SORB_HDR_LEN    8'h04
`define SORB_DESC_LEN   8'h08
`define SORB_TO_LEN     8'h0c
`define SORB_TO_DLEN    8'h0a
`define SORB_OPT_ALL    3'h0
`define SORB_OPT_OP     3'h1
`define SORB_OPT_OPSA   3'h2
`define SORB_OPT_OPSAZ  3'h3
`define SORB_SUP_NA     3'h0
`define SORB_SUP_NO     3'h1
`define SORB_SUP_STD    3'h3
`define SORB_SUP_VEND   3'h5
`define SORB_D_OPCODE   8'h00
`define SORB_D_SA_HI    8'h02
`define SORB_D_SA_LO    8'h03
`define SORB_D_FLAGS    8'h05
`define SORB_D_LEN_LO   8'h07
`define SORB_D_TO       8'h08
`define SORB_O_FLAGS    8'h01
`define SORB_O_SIZE_LO  8'h03
`define SORB_O_USAGE    8'h04
`define SORB_T_LEN_LO   8'h01
`define SORB_T_CSPEC    8'h03
`define SORB_T_NOM      8'h04
`define SORB_T_REC      8'h08
`endif

//--- sorb_pkg.sv
// Purpose: types of the supported opcode report builder
// Assumes: sorb_defs.svh holds every number but the state codes and field widths
// Notes:   builder state is one packed struct, sorb_regs_t
package sorb_pkg;
`include "sorb_defs.svh"

    typedef enum logic [2:0]
    {
        SORB_IDLE = 3'b001,
        SORB_SCAN = 3'b010,
        SORB_SEND = 3'b100
    } sorb_state_t;

    typedef struct packed
    {
        sorb_state_t state;
        logic        full;
        logic [2:0]  option;
        logic [7:0]  opcode;
        logic [15:0] sa;
        logic [31:0] alloc;
        logic [3:0]  idx;
        logic [7:0]  off;
        logic        hdr;
        logic [15:0] total;
        logic [31:0] limit;
        logic [31:0] sent;
        logic [2:0]  support;
        logic [7:0]  data;
        logic        valid;
        logic        last;
        logic        done;
        logic        illegal;
    } sorb_regs_t;
endpackage

//--- sorb_cmd_catalog.sv
// Purpose: constant catalogue of supported commands
// Assumes: index beyond the last entry reads all zero
// Notes:   usage maps are written CDB byte 0 first
`timescale 1ns/1ns
module sorb_cmd_catalog
    import sorb_pkg::*;
(
    input  wire logic [3:0]   idx,
    output logic      [7:0]   opcode,
    output logic              has_sa,
    output logic      [15:0]  sa,
    output logic      [7:0]   sa_pos,
    output logic      [7:0]   cdb_len,
    output logic              timeouts_present_flag,
    output logic              vendor,
    output logic      [127:0] usage,
    output logic      [7:0]   cspec,
    output logic      [31:0]  nominal,
    output logic      [31:0]  recommended
);

    // ****************************************************
    // Catalogue lookup
    // ****************************************************
    // One entry per opcode/SA pair; reserved fields are zero in maps
    always_comb
    begin
        opcode      = 8'h00;
        has_sa      = 1'b0;
        sa          = 16'h0000;
        sa_pos      = 8'h00;
        cdb_len     = 8'h00;
        timeouts_present_flag = 1'b0;
        vendor      = 1'b0;
        usage       = 128'h0;
        cspec       = 8'h00;
        nominal     = 32'h0000_0000;
        recommended = 32'h0000_0000;
        case (idx)
            4'h0:
            begin
                opcode  = 8'h00;
                cdb_len = 8'h06;
                usage   = 128'h00_00_00_00_00_07_00_00_00_00_00_00_00_00_00_00;
            end
            4'h1:
            begin
                opcode      = 8'h12;
                cdb_len     = 8'h06;
                timeouts_present_flag = 1'b1;
                usage       = 128'h00_01_ff_ff_ff_07_00_00_00_00_00_00_00_00_00_00;
                nominal     = 32'h0000_0001;
                recommended = 32'h0000_0005;
            end
            4'h2:
            begin
                opcode  = 8'h28;
                cdb_len = 8'h0a;
                usage   = 128'h00_fe_ff_ff_ff_ff_1f_ff_ff_07_00_00_00_00_00_00;
            end
            4'h3:
            begin
                opcode      = 8'ha3;
                has_sa      = 1'b1;
                sa          = 16'h000c;
                sa_pos      = 8'h01;
                cdb_len     = 8'h0c;
                timeouts_present_flag = 1'b1;
                usage       = 128'h00_00_87_ff_ff_ff_ff_ff_ff_ff_00_07_00_00_00_00;
                nominal     = 32'h0000_0002;
                recommended = 32'h0000_000a;
            end
            4'h4:
            begin
                opcode  = 8'hc1;
                cdb_len = 8'h06;
                vendor  = 1'b1;
                usage   = 128'h00_00_ff_ff_00_07_00_00_00_00_00_00_00_00_00_00;
            end
            default:
            begin
                opcode = 8'h00;
            end
        endcase
    end

endmodule // sorb_cmd_catalog

//--- sorb_report_builder.sv
// Purpose: streams supported-opcode parameter data bytewise
// Assumes: request and stream partners share CLK
// Notes:   one request at a time; REQ_READY shows idle
`timescale 1ns/1ns
`include "sorb_defs.svh"
module sorb_report_builder
    import sorb_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic [2:0]  REQ_OPTION,
    input  wire logic [7:0]  REQ_OPCODE,
    input  wire logic [15:0] REQ_SA,
    input  wire logic [31:0] REQ_ALLOC,
    input  wire logic        CATALOG_READY,
    output logic             REQ_ILLEGAL,
    output logic             RESP_DONE,
    output logic [7:0]       TX_DATA,
    output logic             TX_VALID,
    output logic             TX_LAST,
    input  wire logic        TX_READY
);

    sorb_regs_t    r_reg;
    sorb_regs_t    r_next;
    logic [7:0]    cat_opcode;
    logic          cat_has_sa;
    logic [15:0]   cat_sa;
    logic [7:0]    cat_sa_pos;
    logic [7:0]    cat_len;
    logic          cat_timeouts_present_flag;
    logic          cat_vendor;
    logic [127:0]  cat_usage;
    logic [7:0]    cat_cspec;
    logic [31:0]   cat_nominal;
    logic [31:0]   cat_rec;
    logic [7:0]    dlen;
    logic          match;
    logic          bad_form;
    logic          ok;
    logic [15:0]   one_total;
    logic [7:0]    cur_byte;

    // ****************************************************
    // Catalogue
    // ****************************************************
    sorb_cmd_catalog u_catalog
    (
        .idx         (r_reg.idx),
        .opcode      (cat_opcode),
        .has_sa      (cat_has_sa),
        .sa          (cat_sa),
        .sa_pos      (cat_sa_pos),
        .cdb_len     (cat_len),
        .timeouts_present_flag (cat_timeouts_present_flag),
        .vendor      (cat_vendor),
        .usage       (cat_usage),
        .cspec       (cat_cspec),
        .nominal     (cat_nominal),
        .recommended (cat_rec)
    );

    // ****************************************************
    // Entry helpers
    // ****************************************************
    // Descriptor grows by the timeouts block only when present
    assign dlen = cat_timeouts_present_flag ? (`SORB_DESC_LEN + `SORB_TO_LEN)
                           : `SORB_DESC_LEN;

    // Option 001b ignores SA; 010b on a plain opcode matches so it is refused
    assign match = (cat_opcode == r_reg.opcode) &&
                   ((r_reg.option == `SORB_OPT_OP) ||
                    (cat_has_sa ? (cat_sa == r_reg.sa)
                                : ((r_reg.option == `SORB_OPT_OPSA) || (r_reg.sa == 16'h0000))));

    // Option/opcode kind mismatches are refused outright
    assign bad_form = ((r_reg.option == `SORB_OPT_OP) && cat_has_sa) ||
                      ((r_reg.option == `SORB_OPT_OPSA) && !cat_has_sa);

    // Only a supported entry exposes fields beyond byte 1
    assign ok = (r_reg.support == `SORB_SUP_STD) ||
                (r_reg.support == `SORB_SUP_VEND);

    // Size, usage and optional timeouts behind the 4-byte head
    assign one_total = 16'(`SORB_HDR_LEN) + 16'(cat_len) +
                       (cat_timeouts_present_flag ? 16'(`SORB_TO_LEN) : 16'h0000);

    // ****************************************************
    // Byte formatting
    // ****************************************************
    // Byte t of the timeouts descriptor, words MSB first
    function automatic logic [7:0] to_byte(input logic [7:0] t);
        logic [7:0] b;
        b = 8'h00;
        if (t == `SORB_T_LEN_LO)
            b = `SORB_TO_DLEN;
        else if (t == `SORB_T_CSPEC)
            b = cat_cspec;
        else if (t >= `SORB_T_NOM && t < `SORB_T_REC)
            b = 8'(cat_nominal >> {(`SORB_T_NOM + 8'h03 - t), 3'b000});
        else if (t >= `SORB_T_REC && t < `SORB_TO_LEN)
            b = 8'(cat_rec >> {(`SORB_T_REC + 8'h03 - t), 3'b000});
        return b;
    endfunction

    // Usage byte k: opcode first, SA in its CDB slot, else map
    function automatic logic [7:0] usage_byte(input logic [7:0] k);
        logic [7:0] b;
        b = 8'(cat_usage >> {(8'h0f - k), 3'b000});
        if (k == 8'h00)
            b = cat_opcode;
        else if (cat_has_sa && k == cat_sa_pos)
            b = b | cat_sa[7:0];
        return b;
    endfunction

    // Byte that goes out at the current position
    always_comb
    begin
        cur_byte = 8'h00;
        if (r_reg.full && r_reg.hdr)
        begin
            // Length counts the bytes after the header
            cur_byte = 8'({16'h0000, r_reg.total - 16'(`SORB_HDR_LEN)}
                          >> {(8'h03 - r_reg.off), 3'b000});
        end
        else if (r_reg.full)
        begin
            if (r_reg.off == `SORB_D_OPCODE)
                cur_byte = cat_opcode;
            else if (r_reg.off == `SORB_D_SA_HI)
                cur_byte = cat_has_sa ? cat_sa[15:8] : 8'h00;
            else if (r_reg.off == `SORB_D_SA_LO)
                cur_byte = cat_has_sa ? cat_sa[7:0] : 8'h00;
            else if (r_reg.off == `SORB_D_FLAGS)
                cur_byte = {6'h00, cat_timeouts_present_flag, cat_has_sa};
            else if (r_reg.off == `SORB_D_LEN_LO)
                cur_byte = cat_len;
            else if (r_reg.off >= `SORB_D_TO)
                cur_byte = to_byte(r_reg.off - `SORB_D_TO);
        end
        else
        begin
            if (r_reg.off == `SORB_O_FLAGS)
                cur_byte = {ok & cat_timeouts_present_flag, 4'h0, r_reg.support};
            else if (r_reg.off == `SORB_O_SIZE_LO)
                cur_byte = ok ? cat_len : 8'h00;
            else if (r_reg.off >= `SORB_O_USAGE &&
                     r_reg.off < `SORB_O_USAGE + cat_len)
                cur_byte = usage_byte(r_reg.off - `SORB_O_USAGE);
            else if (r_reg.off >= `SORB_O_USAGE + cat_len)
                cur_byte = to_byte(r_reg.off - `SORB_O_USAGE - cat_len);
        end
    end

    // ****************************************************
    // Sequencer
    // ****************************************************
    // Search or size the answer, then stream it out bytewise
    always_comb
    begin
        r_next         = r_reg;
        r_next.done    = 1'b0;
        r_next.illegal = 1'b0;
        case (r_reg.state)
            SORB_IDLE:
            begin
                if (REQ_VALID)
                begin
                    r_next.option = REQ_OPTION;
                    r_next.opcode = REQ_OPCODE;
                    r_next.sa     = REQ_SA;
                    r_next.alloc  = REQ_ALLOC;
                    r_next.idx    = 4'h0;
                    r_next.off    = 8'h00;
                    r_next.sent   = 32'h0000_0000;
                    r_next.total  = 16'(`SORB_HDR_LEN);
                    r_next.valid  = 1'b0;
                    r_next.last   = 1'b0;
                    r_next.hdr    = 1'b0;
                    r_next.full   = (REQ_OPTION == `SORB_OPT_ALL);
                    if (REQ_OPTION == `SORB_OPT_ALL)
                        r_next.state = SORB_SCAN;
                    else if (REQ_OPTION > `SORB_OPT_OPSAZ)
                        r_next.illegal = 1'b1;
                    else if (!CATALOG_READY)
                    begin
                        // Nothing valid after byte 1 yet
                        r_next.support = `SORB_SUP_NA;
                        r_next.idx     = `SORB_NUM_CMDS;
                        r_next.limit   = (REQ_ALLOC < 32'(`SORB_HDR_LEN)) ?
                                         REQ_ALLOC : 32'(`SORB_HDR_LEN);
                        r_next.state   = SORB_SEND;
                    end
                    else
                        r_next.state = SORB_SCAN;
                end
            end
            SORB_SCAN:
            begin
                if (r_reg.full)
                begin
                    if (r_reg.idx == `SORB_NUM_CMDS)
                    begin
                        r_next.hdr   = 1'b1;
                        r_next.off   = 8'h00;
                        r_next.limit = (r_reg.alloc < {16'h0000, r_reg.total}) ?
                                       r_reg.alloc : {16'h0000, r_reg.total};
                        r_next.state = SORB_SEND;
                    end
                    else
                    begin
                        // One descriptor per catalogue entry
                        r_next.total = r_reg.total + 16'(dlen);
                        r_next.idx   = r_reg.idx + 4'h1;
                    end
                end
                else if (r_reg.idx == `SORB_NUM_CMDS)
                begin
                    r_next.support = `SORB_SUP_NO;
                    r_next.limit   = (r_reg.alloc < 32'(`SORB_HDR_LEN)) ?
                                     r_reg.alloc : 32'(`SORB_HDR_LEN);
                    r_next.state   = SORB_SEND;
                end
                else if (match && bad_form)
                begin
                    r_next.illegal = 1'b1;
                    r_next.state   = SORB_IDLE;
                end
                else if (match)
                begin
                    r_next.support = cat_vendor ? `SORB_SUP_VEND
                                                : `SORB_SUP_STD;
                    r_next.total   = one_total;
                    r_next.limit   = (r_reg.alloc < {16'h0000, one_total}) ?
                                     r_reg.alloc : {16'h0000, one_total};
                    r_next.state   = SORB_SEND;
                end
                else
                    r_next.idx = r_reg.idx + 4'h1;
            end
            SORB_SEND:
            begin
                if (!r_reg.valid || TX_READY)
                begin
                    if (r_reg.sent < r_reg.limit)
                    begin
                        r_next.data  = cur_byte;
                        r_next.valid = 1'b1;
                        r_next.last  = (r_reg.sent + 32'h1 == r_reg.limit);
                        r_next.sent  = r_reg.sent + 32'h1;
                        r_next.off   = r_reg.off + 8'h01;
                        if (r_reg.full && r_reg.hdr &&
                            r_reg.off == `SORB_HDR_LEN - 8'h01)
                        begin
                            r_next.hdr = 1'b0;
                            r_next.off = 8'h00;
                            r_next.idx = 4'h0;
                        end
                        else if (r_reg.full && !r_reg.hdr &&
                                 r_reg.off == dlen - 8'h01)
                        begin
                            r_next.off = 8'h00;
                            r_next.idx = r_reg.idx + 4'h1;
                        end
                    end
                    else
                    begin
                        r_next.valid = 1'b0;
                        r_next.last  = 1'b0;
                        r_next.done  = 1'b1;
                        r_next.state = SORB_IDLE;
                    end
                end
            end
            default:
            begin
                r_next.state = SORB_IDLE;
            end
        endcase
    end

    // ****************************************************
    // State register
    // ****************************************************
    // Async reset to constants only
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            r_reg       <= '0;
            r_reg.state <= SORB_IDLE;
        end
        else
            r_reg <= r_next;
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign REQ_READY   = (r_reg.state == SORB_IDLE);
    assign REQ_ILLEGAL = r_reg.illegal;
    assign RESP_DONE   = r_reg.done;
    assign TX_DATA     = r_reg.data;
    assign TX_VALID    = r_reg.valid;
    assign TX_LAST     = r_reg.last;

endmodule // sorb_report_builder

//--- sorb_props.sv
// Purpose: timing and format checks on the report stream
// Assumes: sees the builder ports only
// Notes:   byte counter restarts at each taken request
`timescale 1ns/1ns
module sorb_props
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        REQ_VALID,
    input wire logic        REQ_READY,
    input wire logic [2:0]  REQ_OPTION,
    input wire logic [31:0] REQ_ALLOC,
    input wire logic        CATALOG_READY,
    input wire logic        REQ_ILLEGAL,
    input wire logic        RESP_DONE,
    input wire logic [7:0]  TX_DATA,
    input wire logic        TX_VALID,
    input wire logic        TX_LAST,
    input wire logic        TX_READY
);
    // ****************************************
    // Byte tracking
    // ****************************************
    logic        take;
    logic [31:0] cnt_reg;
    logic [31:0] alloc_reg;
    logic [2:0]  opt_reg;
    logic        cat_reg;
    assign take = REQ_VALID && REQ_READY;
    // Request fields latched so checks survive the requester moving on
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cnt_reg   <= 32'h0;
            alloc_reg <= 32'h0;
            opt_reg   <= 3'h0;
            cat_reg   <= 1'b0;
        end
        else if (take)
        begin
            cnt_reg   <= 32'h0;
            alloc_reg <= REQ_ALLOC;
            opt_reg   <= REQ_OPTION;
            cat_reg   <= CATALOG_READY;
        end
        else if (TX_VALID && TX_READY)
            cnt_reg <= cnt_reg + 32'h1;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_opt0_legal; take && REQ_OPTION == 3'h0 |=> !REQ_ILLEGAL [*6]; endproperty
    a_opt0_legal: assert property (p_opt0_legal) else $error("full list refused");
    property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST); endproperty
    a_hold: assert property (p_hold) else $error("byte changed before taken");
    property p_done; TX_VALID && TX_READY && TX_LAST |=> !TX_VALID ##[0:1] RESP_DONE; endproperty
    a_done: assert property (p_done) else $error("no done after last byte");
    property p_alloc; TX_VALID |-> cnt_reg < alloc_reg; endproperty
    a_alloc: assert property (p_alloc) else $error("byte beyond allocation");
    property p_idle; REQ_READY |-> !TX_VALID; endproperty
    a_idle: assert property (p_idle) else $error("stream while idle");
    property p_byte0; TX_VALID && cnt_reg == 32'h0 |-> TX_DATA == 8'h00; endproperty
    a_byte0: assert property (p_byte0) else $error("first byte not zero");
    property p_support; TX_VALID && cnt_reg == 32'h1 && opt_reg != 3'h0
        |-> TX_DATA[6:3] == 4'h0 && TX_DATA[2:0] inside {3'h0, 3'h1, 3'h3, 3'h5}; endproperty
    a_support: assert property (p_support) else $error("bad support byte");
    property p_navail; TX_VALID && cnt_reg == 32'h1 && opt_reg != 3'h0 && !cat_reg |-> TX_DATA == 8'h00; endproperty
    a_navail: assert property (p_navail) else $error("not ready but supported");
    property p_hdr; TX_VALID && cnt_reg == 32'h3 && opt_reg == 3'h0 |-> TX_DATA == 8'h40; endproperty
    a_hdr: assert property (p_hdr) else $error("bad list length");
    c_list: cover property (TX_VALID && TX_LAST && opt_reg == 3'h0);
    c_illegal: cover property (REQ_ILLEGAL);
    c_navail: cover property (RESP_DONE && !cat_reg);
endmodule // sorb_props

//--- sorb_sink.sv
// Purpose: requester side taking the report bytes
// Assumes: shares CLK with the builder
// Notes:   slow mode toggles ready every cycle
`timescale 1ns/1ns
module sorb_sink
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    input  wire logic       TX_LAST,
    input  wire logic       STALL,
    output logic            TX_READY
);
    logic [7:0] got[$];
    int         last_at;
    // Toggling ready makes each byte after the first wait a cycle, so holding is exercised
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
            TX_READY <= 1'b0;
        else
            TX_READY <= STALL ? !TX_READY : 1'b1;
    end
    // Bytes are only taken on an edge with valid and ready
    always @(posedge CLK)
    begin
        if (!RST && TX_VALID && TX_READY)
        begin
            if (TX_LAST)
                last_at = got.size();
            got.push_back(TX_DATA);
        end
    end
endmodule // sorb_sink

//--- tb.sv
// Purpose: self-checking bench of the report builder
// Assumes: fixed command catalogue of the design
// Notes:   one task per scenario, bytes judged after the run
`timescale 1ns/1ns
module tb;
    logic CLK, RST, REQ_VALID, REQ_READY, CATALOG_READY, REQ_ILLEGAL, RESP_DONE;
    logic TX_VALID, TX_LAST, TX_READY, stall, ill;
    logic [2:0]  REQ_OPTION;
    logic [7:0]  REQ_OPCODE, TX_DATA;
    logic [15:0] REQ_SA;
    logic [31:0] REQ_ALLOC;
    int          failures, checked;
    // Expected full list: header then five descriptors
    localparam logic [543:0] FULL = {32'h00000040, 64'h0000000000000006,
        160'h1200000000020006_000a0000_00000001_00000005, 64'h280000000000000a,
        160'ha300000c0003000c_000a0000_00000002_0000000a, 64'hc100000000000006};
    sorb_report_builder DUT (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
        .REQ_OPTION(REQ_OPTION), .REQ_OPCODE(REQ_OPCODE), .REQ_SA(REQ_SA), .REQ_ALLOC(REQ_ALLOC),
        .CATALOG_READY(CATALOG_READY), .REQ_ILLEGAL(REQ_ILLEGAL), .RESP_DONE(RESP_DONE),
        .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY));
    sorb_sink u_sink (.CLK(CLK), .RST(RST), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .TX_LAST(TX_LAST), .STALL(stall), .TX_READY(TX_READY));
    always #25 CLK = ~CLK;
    // ****************************************
    // Compare and transfer tasks
    // ****************************************
    task automatic bad(input string m);
        failures++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
            bad($sformatf("byte %h expected %h", g, e));
    endtask
    task automatic chk1(input logic g, input logic e);
        checked++;
        if (g !== e)
            bad("refusal flag wrong");
    endtask
    task automatic chk_n(input int g, input int e);
        checked++;
        if (g != e)
            bad($sformatf("count %0d expected %0d", g, e));
    endtask
    // One request pulse, then wait for done or refusal under a bound
    task automatic run(input logic [2:0] o, input logic [7:0] op, input logic [15:0] sa, input logic [31:0] al);
        int n;
        u_sink.got.delete();
        u_sink.last_at = -1;
        n = 0;
        @(posedge CLK);
        REQ_VALID  <= 1'b1;
        REQ_OPTION <= o;
        REQ_OPCODE <= op;
        REQ_SA     <= sa;
        REQ_ALLOC  <= al;
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        // A reserved option is refused on the taking edge itself
        #1;
        while (n < 2000 && RESP_DONE !== 1'b1 && REQ_ILLEGAL !== 1'b1)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        ill = REQ_ILLEGAL;
        if (n >= 2000)
            bad("no completion");
    endtask
    task automatic fin(input int e);
        chk_n(u_sink.got.size(), e);
        if (e > 0)
            chk_n(u_sink.last_at, e - 1);
    endtask
    task automatic one(input logic [2:0] o, input logic [7:0] op, input logic [15:0] sa, input logic [7:0] b1, input int sz);
        run(o, op, sa, 32'h3e8);
        fin(4 + sz + (b1[7] ? 12 : 0));
        chk8(u_sink.got[1], b1);
        chk8(u_sink.got[2], 8'h00);
        chk8(u_sink.got[3], 8'(sz));
        if (sz > 0)
            chk8(u_sink.got[4], op);
        if (b1[7])
            chk8(u_sink.got[5 + sz], 8'h0a);
    endtask
    task automatic refuse(input logic [2:0] o, input logic [7:0] op, input logic [15:0] sa);
        run(o, op, sa, 32'h3e8);
        chk1(ill, 1'b1);
        chk_n(u_sink.got.size(), 0);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_full();
        stall <= 1'b1;
        run(3'h0, 8'h55, 16'hffff, 32'h3e8);
        stall = 1'b0;
        chk1(ill, 1'b0);
        fin(68);
        for (int i = 0; i < 68; i++)
            chk8(u_sink.got[i], FULL[543 - 8 * i -: 8]);
        $display("full list slow sink done");
    endtask
    task automatic t_trunc();
        run(3'h0, 8'h00, 16'h0000, 32'ha);
        fin(10);
        for (int i = 0; i < 10; i++)
            chk8(u_sink.got[i], FULL[543 - 8 * i -: 8]);
        run(3'h0, 8'h00, 16'h0000, 32'h0);
        fin(0);
        $display("truncation done");
    endtask
    task automatic t_one();
        one(3'h1, 8'h12, 16'h0000, 8'h83, 6);
        one(3'h2, 8'ha3, 16'h000c, 8'h83, 12);
        one(3'h3, 8'ha3, 16'h000c, 8'h83, 12);
        chk8(u_sink.got[5] & 8'h1f, 8'h0c);
        one(3'h1, 8'hc1, 16'h0000, 8'h05, 6);
        one(3'h3, 8'h28, 16'h0000, 8'h03, 10);
        one(3'h1, 8'h55, 16'h0000, 8'h01, 0);
        one(3'h3, 8'ha3, 16'h000d, 8'h01, 0);
        $display("single command done");
    endtask
    task automatic t_navail();
        @(posedge CLK);
        CATALOG_READY <= 1'b0;
        one(3'h1, 8'h28, 16'h0000, 8'h00, 0);
        @(posedge CLK);
        CATALOG_READY <= 1'b1;
        one(3'h1, 8'h28, 16'h0000, 8'h03, 10);
        $display("not available and retry done");
    endtask
    task automatic t_refuse();
        for (int o = 4; o < 8; o++)
            refuse(3'(o), 8'h12, 16'h0000);
        refuse(3'h1, 8'ha3, 16'h000c);
        refuse(3'h2, 8'h28, 16'h0000);
        refuse(3'h2, 8'h28, 16'h0001);
        $display("refusals done");
    endtask
    task automatic print_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence after three reset cycles
    initial
    begin
        CLK = 1'b0;
        RST = 1'b1;
        REQ_VALID = 1'b0;
        REQ_OPTION = 3'h0;
        REQ_OPCODE = 8'h00;
        REQ_SA = 16'h0000;
        REQ_ALLOC = 32'h0;
        CATALOG_READY = 1'b1;
        stall = 1'b0;
        failures = 0;
        checked = 0;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        t_full();
        t_trunc();
        t_one();
        t_navail();
        t_refuse();
        print_verdict();
    end
    // Whole run needs well under a thousand cycles; 20000 cycles is far beyond
    initial
    begin
        #1000000;
        bad("watchdog expired");
        print_verdict();
    end
endmodule // tb
bind sorb_report_builder sorb_props u_props (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_OPTION(REQ_OPTION), .REQ_ALLOC(REQ_ALLOC), .CATALOG_READY(CATALOG_READY),
    .REQ_ILLEGAL(REQ_ILLEGAL), .RESP_DONE(RESP_DONE), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_LAST(TX_LAST), .TX_READY(TX_READY));
